// *** logic/tashp_shaper.sv ***
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module tashp_shaper
   import tashp_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   // modulation control
   input wire logic carrier_tick,
   input wire logic mod_req,
   input wire logic rate_848,
   input wire logic [7:0] pa_supply_voltage,
   // transmitter drive
   output logic [7:0] tx_amplitude,
   output logic [1:0] tx_phase
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [7:0][7:0] cfg;
      tashp_phase_e phase;
      logic [4:0] idx;
      logic half;
      logic [2:0] hold;
      logic set848;
      logic [7:0] amp;
      logic [7:0] rd;
   } tashp_state_s;

   tashp_state_s s_q;
   tashp_state_s s_d;

   // ----------------------------------------------------------------------
   // parameter set selection
   // ----------------------------------------------------------------------
   logic sel848;
   logic [2:0] base;
   logic [7:0] res_a;
   logic [3:0] kind_f;
   logic [3:0] kind_r;
   logic [2:0] style_f;
   logic [2:0] style_r;
   logic dbl;
   logic [4:0] nstates;

   // the set follows the live rate only while idle; an edge keeps its set
   assign sel848 = (s_q.phase == TASHP_CARRIER) ? rate_848 : s_q.set848;
   assign base = sel848 ? TASHP_SET_848_BASE : 3'h0;
   assign res_a = s_q.cfg[base + TASHP_SLOT_RES];
   assign kind_f = s_q.cfg[base + TASHP_SLOT_KIND][TASHP_KIND_FALL_LSB +: 4];
   assign kind_r = s_q.cfg[base + TASHP_SLOT_KIND][TASHP_KIND_RISE_LSB +: 4];
   assign style_f = s_q.cfg[base + TASHP_SLOT_STYLE][TASHP_STYLE_FALL_LSB +: 3];
   assign style_r = s_q.cfg[base + TASHP_SLOT_STYLE][TASHP_STYLE_RISE_LSB +: 3];
   assign dbl = s_q.cfg[base + TASHP_SLOT_LEN][TASHP_LEN_DOUBLE_BIT];
   assign nstates = s_q.cfg[base + TASHP_SLOT_LEN][TASHP_LEN_COUNT_MSB:0];

   // ----------------------------------------------------------------------
   // edge shape arithmetic
   // ----------------------------------------------------------------------
   logic falling;
   logic [3:0] kind_c;
   logic [2:0] style_c;
   logic fw_f;
   logic fw_r;
   logic ok_f;
   logic ok_r;
   logic [13:0] num;
   logic [13:0] quot;
   logic [8:0] lin;
   logic [8:0] lut_v;
   logic [16:0] scaled;
   logic [8:0] frac;
   logic [7:0] delta;
   logic [16:0] prod;
   logic [7:0] swing;
   logic [7:0] shaped;
   logic [7:0] kept;

   assign falling = (s_q.phase == TASHP_FALL);
   assign kind_c = falling ? kind_f : kind_r;
   assign style_c = falling ? style_f : style_r;
   assign fw_f = (kind_f >= TASHP_KIND_LIN1) && (kind_f <= TASHP_KIND_LIN3);
   assign fw_r = (kind_r >= TASHP_KIND_LIN1) && (kind_r <= TASHP_KIND_LIN3);
   // reserved codes and a zero state count fall back to a hard edge
   assign ok_f = (kind_f >= TASHP_KIND_LIN1) && (kind_f <= TASHP_KIND_LUT_NOCORR) && (nstates != 5'h00);
   assign ok_r = (kind_r >= TASHP_KIND_LIN1) && (kind_r <= TASHP_KIND_LUT_NOCORR) && (nstates != 5'h00);

   // linear progress after state idx, in 1/256 of the swing
   assign num = {1'b0, ({1'b0, s_q.idx} + 6'h01), 7'h00} << 1;
   assign quot = (nstates == 5'h00) ? 14'h0100 : num / {9'h000, nstates};
   assign lin = (quot >= 14'h0100) ? TASHP_FRAC_ONE : quot[8:0];
   // table point, the last state always lands on the full swing
   assign lut_v = (lin == TASHP_FRAC_ONE) ? TASHP_FRAC_ONE : {1'b0, TASHP_LUT[style_c[1:0]][lin[7:5]]};
   // supply scaling for the adaptive table kinds
   assign scaled = lut_v * {9'h000, pa_supply_voltage};

   // progress to fraction per kind
   always_comb begin
      case (kind_c)
         TASHP_KIND_LIN1: frac = lin;
         TASHP_KIND_LIN2: begin
            if (lin < 9'h080) begin
               frac = lin + {1'b0, lin[8:1]};
            end else begin
               frac = 9'h080 + {1'b0, lin[8:1]};
            end
         end
         TASHP_KIND_LIN3: begin
            if (lin < 9'h040) begin
               frac = {lin[7:0], 1'b0};
            end else if (lin < 9'h0C0) begin
               frac = 9'h080 + {1'b0, lin[8:1]} - 9'h020;
            end else begin
               frac = lin;
            end
         end
         TASHP_KIND_LUT_FIX: frac = lut_v;
         TASHP_KIND_LUT_CORR: frac = scaled[16:8];
         TASHP_KIND_LUT_NOCORR: frac = scaled[16:8];
         default: frac = TASHP_FRAC_ONE;
      endcase
   end

   // scale the swing between full carrier and the residual level
   assign delta = TASHP_FULL_AMPL - res_a;
   assign prod = {8'h00, frac} * {9'h000, delta};
   assign swing = (prod[16:8] > {1'b0, delta}) ? delta : prod[15:8];
   assign shaped = falling ? (TASHP_FULL_AMPL - swing) : (res_a + swing);
   // uncorrected edges start where the last one stopped, so they must never turn back
   assign kept = falling ? ((shaped < s_q.amp) ? shaped : s_q.amp)
                         : ((shaped > s_q.amp) ? shaped : s_q.amp);

   // ----------------------------------------------------------------------
   // next state: register port and edge sequencer
   // ----------------------------------------------------------------------
   logic [7:0] woff;
   logic [7:0] roff;
   logic edge_end;

   assign woff = addr - TASHP_ADDR_FIRST;
   assign roff = addr - TASHP_ADDR_FIRST;
   // last state of the edge expires on this tick
   assign edge_end = carrier_tick && (!dbl || s_q.half) && (s_q.hold == 3'h0) && (s_q.idx == nstates - 5'h01);

   always_comb begin
      s_d = s_q;
      // read data stand one cycle, zero for unmapped offsets
      s_d.rd = 8'h00;
      if (rd_en) begin
         if ((addr >= TASHP_ADDR_FIRST) && (addr <= TASHP_ADDR_LAST)) begin
            s_d.rd = s_q.cfg[roff[2:0]];
         end else if (addr == TASHP_ADDR_STATUS) begin
            s_d.rd = {s_q.phase, s_q.set848, s_q.idx};
         end
      end
      // reserved bits are stored as written
      if (wr_en && (addr >= TASHP_ADDR_FIRST) && (addr <= TASHP_ADDR_LAST)) begin
         s_d.cfg[woff[2:0]] = wr_data;
      end
      case (s_q.phase)
         TASHP_CARRIER: begin
            if (kind_r != TASHP_KIND_LUT_NOCORR) begin
               s_d.amp = TASHP_FULL_AMPL;
            end
            if (mod_req) begin
               s_d.set848 = rate_848;
               s_d.idx = 5'h00;
               s_d.half = 1'b0;
               s_d.hold = fw_f ? style_f : 3'h0;
               s_d.phase = ok_f ? TASHP_FALL : TASHP_MOD;
            end
         end
         TASHP_MOD: begin
            // uncorrected table edges keep the level they ended on
            if (kind_f != TASHP_KIND_LUT_NOCORR) begin
               s_d.amp = res_a;
            end
            if (!mod_req) begin
               s_d.idx = 5'h00;
               s_d.half = 1'b0;
               s_d.hold = fw_r ? style_r : 3'h0;
               s_d.phase = ok_r ? TASHP_RISE : TASHP_CARRIER;
            end
         end
         TASHP_FALL, TASHP_RISE: begin
            // time constant states hold the start level before the ramp
            if (s_q.hold != 3'h0) begin
               s_d.amp = falling ? TASHP_FULL_AMPL : res_a;
            end else if (kind_c == TASHP_KIND_LUT_NOCORR) begin
               s_d.amp = kept;
            end else begin
               s_d.amp = shaped;
            end
            if (carrier_tick) begin
               if (dbl && !s_q.half) begin
                  s_d.half = 1'b1;
               end else begin
                  s_d.half = 1'b0;
                  if (s_q.hold != 3'h0) begin
                     s_d.hold = s_q.hold - 3'h1;
                  end else if (edge_end) begin
                     s_d.idx = 5'h00;
                     s_d.phase = falling ? TASHP_MOD : TASHP_CARRIER;
                  end else begin
                     s_d.idx = s_q.idx + 5'h01;
                  end
               end
            end
         end
         default: s_d.phase = TASHP_CARRIER;
      endcase
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   // synchronous reset: full carrier, all settings zero
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_q.cfg <= {8{TASHP_CFG_RESET}};
         s_q.phase <= TASHP_CARRIER;
         s_q.idx <= 5'h00;
         s_q.half <= 1'b0;
         s_q.hold <= 3'h0;
         s_q.set848 <= 1'b0;
         s_q.amp <= TASHP_FULL_AMPL;
         s_q.rd <= 8'h00;
      end else begin
         s_q <= s_d;
      end
   end

   assign rd_data = s_q.rd;
   assign tx_amplitude = s_q.amp;
   assign tx_phase = s_q.phase;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   a_fall_monotonic:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_q.phase == TASHP_FALL && $past(s_q.phase) == TASHP_FALL) |-> s_q.amp <= $past(s_q.amp))
      else $error("falling edge amplitude rose");

   a_mod_level:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_q.phase == TASHP_MOD && kind_f != TASHP_KIND_LUT_NOCORR && !wr_en) |=>
      (s_q.phase != TASHP_MOD || s_q.amp == $past(res_a)))
      else $error("corrected edge did not settle on residual level");

   a_rise_monotonic:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_q.phase == TASHP_RISE && $past(s_q.phase) == TASHP_RISE && !$past(wr_en)) |->
      s_q.amp >= $past(s_q.amp))
      else $error("rising edge amplitude fell");

   a_fall_hold:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_q.phase == TASHP_FALL && s_q.hold != 3'h0) |=> s_q.amp == TASHP_FULL_AMPL)
      else $error("falling time constant state left full carrier");

   a_hold_load:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_q.phase == TASHP_MOD && !mod_req && ok_r && !wr_en) |=>
      (s_q.phase == TASHP_RISE && s_q.hold == (fw_r ? style_r : 3'h0)))
      else $error("rising time constant not loaded");

   a_double_state:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_q.phase == TASHP_FALL && carrier_tick && dbl && !s_q.half && !wr_en) |=>
      (s_q.half && $stable(s_q.idx) && $stable(s_q.hold)))
      else $error("doubled state advanced after one carrier cycle");

   a_state_count:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_q.phase == TASHP_FALL || s_q.phase == TASHP_RISE) && !$past(wr_en) |-> s_q.idx < nstates)
      else $error("state index beyond active state count");

   a_set_stable:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_q.phase != TASHP_CARRIER && $past(s_q.phase) != TASHP_CARRIER) |-> $stable(s_q.set848))
      else $error("bit-rate set changed during modulation");

   a_idle_full:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_q.phase == TASHP_CARRIER && kind_r != TASHP_KIND_LUT_NOCORR && !mod_req) |=>
      s_q.amp == TASHP_FULL_AMPL)
      else $error("idle carrier not at full amplitude");

   a_hard_fall:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_q.phase == TASHP_CARRIER && mod_req && !ok_f) |=> s_q.phase == TASHP_MOD)
      else $error("reserved falling kind did not give a hard edge");

   a_fall_lands:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_q.phase == TASHP_FALL && edge_end && fw_f) |=> s_q.amp == $past(res_a))
      else $error("linear falling edge missed the residual level");

   a_rise_lands:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_q.phase == TASHP_RISE && edge_end && fw_r) |=> s_q.amp == TASHP_FULL_AMPL)
      else $error("linear rising edge missed full carrier");

   a_rise_hold:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_q.phase == TASHP_RISE && s_q.hold != 3'h0) |=> s_q.amp == $past(res_a))
      else $error("rising time constant state left residual level");

   a_rise_double:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_q.phase == TASHP_RISE && carrier_tick && dbl && !s_q.half && !wr_en) |=>
      (s_q.half && $stable(s_q.idx) && $stable(s_q.hold)))
      else $error("doubled rising state advanced after one carrier cycle");

   a_edge_close:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_q.phase == TASHP_FALL && edge_end) |=> s_q.phase == TASHP_MOD)
      else $error("falling edge outlived its state count");

   a_rate_latch:
   assert property (@(posedge core_clk) disable iff (!rst_n)
      (s_q.phase == TASHP_CARRIER && mod_req) |=> s_q.set848 == $past(rate_848))
      else $error("bit-rate set not taken at edge start");

endmodule // tashp_shaper

// *** logic/tashp_pkg.sv ***
// ----------------------------------------------------------------------
// constants for the type A transmit edge shaper
// ----------------------------------------------------------------------
package tashp_pkg;
   // register offsets, one byte each
   localparam logic [7:0] TASHP_ADDR_RES_424 = 8'h1C;
   localparam logic [7:0] TASHP_ADDR_KIND_424 = 8'h1D;
   localparam logic [7:0] TASHP_ADDR_STYLE_424 = 8'h1E;
   localparam logic [7:0] TASHP_ADDR_LEN_424 = 8'h1F;
   localparam logic [7:0] TASHP_ADDR_RES_848 = 8'h20;
   localparam logic [7:0] TASHP_ADDR_KIND_848 = 8'h21;
   localparam logic [7:0] TASHP_ADDR_STYLE_848 = 8'h22;
   localparam logic [7:0] TASHP_ADDR_LEN_848 = 8'h23;
   localparam logic [7:0] TASHP_ADDR_STATUS = 8'h30;
   localparam logic [7:0] TASHP_ADDR_FIRST = TASHP_ADDR_RES_424;
   localparam logic [7:0] TASHP_ADDR_LAST = TASHP_ADDR_LEN_848;

   // slot of each setting inside one bit-rate set, and set stride
   localparam logic [2:0] TASHP_SLOT_RES = 3'h0;
   localparam logic [2:0] TASHP_SLOT_KIND = 3'h1;
   localparam logic [2:0] TASHP_SLOT_STYLE = 3'h2;
   localparam logic [2:0] TASHP_SLOT_LEN = 3'h3;
   localparam logic [2:0] TASHP_SET_848_BASE = 3'h4;

   // field positions
   localparam int TASHP_KIND_FALL_LSB = 4;
   localparam int TASHP_KIND_RISE_LSB = 0;
   localparam int TASHP_STYLE_FALL_LSB = 4;
   localparam int TASHP_STYLE_RISE_LSB = 0;
   localparam int TASHP_LEN_DOUBLE_BIT = 7;
   localparam int TASHP_LEN_COUNT_MSB = 4;

   // edge kind codes
   localparam logic [3:0] TASHP_KIND_LIN1 = 4'h1;
   localparam logic [3:0] TASHP_KIND_LIN2 = 4'h2;
   localparam logic [3:0] TASHP_KIND_LIN3 = 4'h3;
   localparam logic [3:0] TASHP_KIND_LUT_FIX = 4'h4;
   localparam logic [3:0] TASHP_KIND_LUT_CORR = 4'h5;
   localparam logic [3:0] TASHP_KIND_LUT_NOCORR = 4'h6;

   // levels and reset values
   localparam logic [7:0] TASHP_FULL_AMPL = 8'hFF;
   localparam logic [7:0] TASHP_CFG_RESET = 8'h00;
   localparam logic [8:0] TASHP_FRAC_ONE = 9'h100;

   // four monotonic edge tables, eight points each, 0xFF near full swing
   localparam logic [7:0] TASHP_LUT [4][8] = '{
      '{8'h08, 8'h20, 8'h48, 8'h80, 8'hB8, 8'hE0, 8'hF8, 8'hFF},
      '{8'h20, 8'h40, 8'h60, 8'h80, 8'hA0, 8'hC0, 8'hE0, 8'hFF},
      '{8'h40, 8'h70, 8'h98, 8'hB8, 8'hD0, 8'hE4, 8'hF4, 8'hFF},
      '{8'h04, 8'h0C, 8'h1C, 8'h34, 8'h58, 8'h88, 8'hC0, 8'hFF}};

   typedef enum logic [1:0] {TASHP_CARRIER, TASHP_FALL, TASHP_MOD, TASHP_RISE} tashp_phase_e;
endpackage

// *** sim/tashp_antenna_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// antenna side: carrier source, edge watcher
// ----------------------------------------
module tashp_antenna_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // transmitter drive
   input wire logic [7:0] tx_amplitude,
   input wire logic [1:0] tx_phase,
   // carrier and observations
   output logic carrier_tick,
   output int fall_ticks,
   output int rise_ticks,
   output int bumps
);
   logic [1:0] div_q;
   logic [7:0] prev_q;
   logic [1:0] prev_phase_q;

   // carrier runs free, one tick per four core cycles so states stay visible
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         div_q <= 2'h0;
         carrier_tick <= 1'b0;
         prev_q <= 8'hFF;
         prev_phase_q <= 2'h0;
         fall_ticks <= 0;
         rise_ticks <= 0;
         bumps <= 0;
      end else begin
         div_q <= div_q + 2'h1;
         carrier_tick <= (div_q == 2'h3);
         prev_q <= tx_amplitude;
         prev_phase_q <= tx_phase;
         if (carrier_tick && tx_phase == 2'h1) fall_ticks <= fall_ticks + 1;
         if (carrier_tick && tx_phase == 2'h3) rise_ticks <= rise_ticks + 1;
         // a falling edge never climbs, a rising edge never sinks; the step into an edge is its start level
         if ((tx_phase == prev_phase_q) &&
            ((tx_phase == 2'h1 && tx_amplitude > prev_q) || (tx_phase == 2'h3 && tx_amplitude < prev_q))) begin
            bumps <= bumps + 1;
         end
      end
   end
endmodule // tashp_antenna_model

// *** sim/tashp_shaper_tb.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// bench for the type A edge shaper
// ----------------------------------------
module tashp_shaper_tb
   import tashp_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wr_data = 8'h00;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [7:0] rd_data;
   logic carrier_tick;
   logic mod_req = 1'b0;
   logic rate_848 = 1'b0;
   logic [7:0] pa_supply_voltage = 8'hFF;
   logic [7:0] tx_amplitude;
   logic [1:0] tx_phase;
   int fall_ticks;
   int rise_ticks;
   int bumps;
   int fails = 0;
   int check_count = 0;
   int cycles = 0;
   // patterns keep reserved bits at zero
   logic [7:0] pat [8] = '{8'hA5, 8'h36, 8'h77, 8'h9F, 8'h5A, 8'h63, 8'h55, 8'h83};

   initial begin
      forever #12.5 core_clk = ~core_clk;
   end

   tashp_shaper tashp_shaper_inst (.core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .carrier_tick(carrier_tick), .mod_req(mod_req),
      .rate_848(rate_848), .pa_supply_voltage(pa_supply_voltage), .tx_amplitude(tx_amplitude),
      .tx_phase(tx_phase));
   tashp_antenna_model tashp_antenna_model_inst (.core_clk(core_clk), .rst_n(rst_n),
      .tx_amplitude(tx_amplitude), .tx_phase(tx_phase), .carrier_tick(carrier_tick),
      .fall_ticks(fall_ticks), .rise_ticks(rise_ticks), .bumps(bumps));

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] want, input string what);
      check_count++;
      if (seen !== want) begin
         fails++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, seen, want);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // one-cycle strobes; the leading edge wait leaves a gap so no signal is set twice at once
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge core_clk);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] want, input string what);
      @(posedge core_clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge core_clk);
      rd_en <= 1'b0;
      #1;
      chk(rd_data, want, what);
   endtask

   task automatic wait_phase(input logic [1:0] p);
      int n;
      n = 0;
      while (tx_phase !== p && n < 600) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk({6'h00, tx_phase}, {6'h00, p}, "phase");
   endtask

   // program one set, modulate, return; strict[0] checks levels, strict[1] ramp direction
   task automatic edge_case(input logic r848, input logic [7:0] kind, input logic [7:0] style,
      input logic [7:0] len, input logic [7:0] res, input int nf, input int nr, input logic [1:0] strict);
      logic [7:0] base;
      int f0;
      int r0;
      int b0;
      base = r848 ? TASHP_ADDR_RES_848 : TASHP_ADDR_RES_424;
      wr(base, res);
      wr(base + 8'h01, kind);
      wr(base + 8'h02, style);
      wr(base + 8'h03, len);
      f0 = fall_ticks;
      r0 = rise_ticks;
      b0 = bumps;
      @(posedge core_clk);
      rate_848 <= r848;
      mod_req <= 1'b1;
      wait_phase(2'h2);
      @(posedge core_clk);
      #1;
      if (strict[0]) chk(tx_amplitude, res, "residual");
      chk(8'(fall_ticks - f0), 8'(nf), "fall states");
      rd(TASHP_ADDR_STATUS, {2'h2, r848, 5'h00}, "status modulated");
      @(posedge core_clk);
      mod_req <= 1'b0;
      wait_phase(2'h0);
      @(posedge core_clk);
      #1;
      if (strict[0]) chk(tx_amplitude, TASHP_FULL_AMPL, "full carrier");
      chk(8'(rise_ticks - r0), 8'(nr), "rise states");
      if (strict[1]) chk(8'(bumps - b0), 8'h00, "ramp direction");
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++) rd(TASHP_ADDR_FIRST + 8'(i), TASHP_CFG_RESET, "reset value");
      rd(TASHP_ADDR_STATUS, 8'h00, "status idle");
      for (int i = 0; i < 8; i++) begin
         wr(TASHP_ADDR_FIRST + 8'(i), pat[i]);
         rd(TASHP_ADDR_FIRST + 8'(i), pat[i], "read back");
      end
      rd(TASHP_ADDR_RES_848, pat[4], "set kept apart");
      wr(8'h24, 8'hFF);
      rd(8'h24, 8'h00, "unmapped");
      rd(8'h1B, 8'h00, "unmapped");
      // reserved kinds give a hard edge with no transition states; the three linear kinds follow with their state counts
      edge_case(1'b0, 8'h00, 8'h00, 8'h02, 8'h00, 0, 0, 2'h3);
      edge_case(1'b0, 8'h77, 8'h00, 8'h02, 8'h30, 0, 0, 2'h3);
      edge_case(1'b0, 8'h11, 8'h00, 8'h02, 8'h00, 2, 2, 2'h3);
      edge_case(1'b0, 8'h22, 8'h31, 8'h03, 8'h40, 6, 4, 2'h3);
      edge_case(1'b0, 8'h33, 8'h00, 8'h84, 8'hFF, 8, 8, 2'h3);
      // tables add no hold states, so mixed kinds split the counts
      edge_case(1'b0, 8'h14, 8'h23, 8'h05, 8'h10, 7, 5, 2'h3);
      edge_case(1'b0, 8'h41, 8'h23, 8'h05, 8'h10, 5, 8, 2'h3);
      @(posedge core_clk);
      pa_supply_voltage <= 8'h80;
      edge_case(1'b0, 8'h55, 8'h10, 8'h04, 8'h20, 4, 4, 2'h1);
      edge_case(1'b0, 8'h66, 8'h32, 8'h03, 8'h20, 3, 3, 2'h0);
      @(posedge core_clk);
      pa_supply_voltage <= 8'hFF;
      edge_case(1'b1, 8'h11, 8'h00, 8'h06, 8'h60, 6, 6, 2'h3);
      edge_case(1'b0, 8'h22, 8'h00, 8'h01, 8'h80, 1, 1, 2'h3);
      conclude();
   end

   // hang guard, far above the several hundred cycles the sequence needs
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         conclude();
      end
   end
endmodule // tashp_shaper_tb
